// *** hdl/ccg_pkg.sv ***
/*
 * Shared constants and types for the codec system clock generator:
 * register addresses, field positions, reset values, divider periods and
 * the switchover state encoding.
 * Assumes a 16-bit register port with 8-bit addresses and one clock.
 */
package ccg_pkg;

    // Register addresses on the device register port.
    localparam logic [7:0] PWR5_ADDR = 8'h0c;
    localparam logic [7:0] CLKSEL_ADDR = 8'h28;
    localparam logic [7:0] RTCTICK_ADDR = 8'hda;

    // Field positions in power_control_five.
    localparam int PWR5_FLL_EN_BIT = 0;
    localparam int PWR5_FLL_OSC_BIT = 1;
    localparam int PWR5_MASTER_BIT = 2;
    localparam int PWR5_REF_LSB = 4;
    localparam int PWR5_XTAL_BIT = 10;
    localparam int PWR5_ACT_BIT = 14;
    localparam int PWR5_BUSY_BIT = 15;

    // Field positions in rtc_tick_config.
    localparam int RTC_XTAL_BIT = 12;

    // Field positions in codec_clock_select.
    localparam int CS_OPDIV_LSB = 0;
    localparam int CS_BCLK_LSB = 4;
    localparam int CS_HALF_BIT = 8;
    localparam int CS_ALT_BIT = 9;
    localparam int CS_OPCLK_BIT = 10;
    localparam int CS_SRC_BIT = 11;
    localparam int CS_USB_BIT = 12;
    localparam int CS_TO_RATE_LSB = 13;
    localparam int CS_TO_EN_BIT = 15;

    // Divider counter width, in clock edges of the source being divided.
    localparam int DIV_W = 24;

    // Internal clock cycles per sample in normal and USB ratio modes.
    localparam logic [8:0] FS_RATIO_NORMAL = 9'h100;
    localparam logic [8:0] FS_RATIO_USB = 9'h110;

    // Frame clock period: 64 bit clocks per phase, counted in bit clock edges.
    localparam logic [DIV_W-1:0] FRAME_PERIOD_EDGES = 24'h000100;

    // Timeout clock base period in system clock edges, shifted by the rate.
    localparam logic [DIV_W-1:0] TOCLK_BASE_EDGES = 24'h008000;

    // Reset value of the crystal oscillator enable.
    localparam logic XTAL_EN_RST = 1'h1;

    // Control fields held by the block.
    typedef struct packed {
        logic to_en;
        logic [1:0] to_rate;
        logic usb;
        logic src;
        logic opclk_en;
        logic alt;
        logic half;
        logic [3:0] bclk_div;
        logic [3:0] op_div;
        logic fll_en;
        logic fll_osc;
        logic master;
        logic [1:0] fll_ref;
    } ccg_cfg_t;

    localparam ccg_cfg_t CFG_RST = '0;

    // One register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ccg_reg_req_t;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_WAIT_OLD_FALL,
        SW_WAIT_NEW_LOW
    } ccg_sw_st_t;

endpackage

// *** hdl/ccg_divider.sv ***
/*
 * Edge-counting clock divider: counts tick pulses (edges of a source clock
 * sampled on ref_clk) and produces a registered clock and, while running, its inverse.
 * Assumes period is at least 2 and tick is a one-cycle pulse.
 */
module ccg_divider
    import ccg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic tick,
    input wire logic [DIV_W-1:0] period,
    output logic clk_out,
    output logic clk_out_b,
    output logic out_edge
);

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic hi_nxt;

    // Output is high for the first half of the period, the larger half when odd.
    always_comb begin
        cnt_nxt = (cnt_r >= period - 24'h000001) ? '0 : cnt_r + 24'h000001;
        hi_nxt = cnt_nxt < (period - (period >> 1));
    end

    // Idle parks the count at the end so the first tick starts a full high phase.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            clk_out <= 1'h0;
            clk_out_b <= 1'h0;
            out_edge <= 1'h0;
        end else if (!run) begin
            cnt_r <= period - 24'h000001;
            clk_out <= 1'h0;
            clk_out_b <= 1'h0;
            out_edge <= 1'h0;
        end else if (tick) begin
            cnt_r <= cnt_nxt;
            clk_out <= hi_nxt;
            clk_out_b <= ~hi_nxt;
            out_edge <= hi_nxt != clk_out;
        end else begin
            out_edge <= 1'h0;
        end
    end

endmodule

// *** hdl/ccg_codec_system_clock.sv ***
/*
 * Codec system clock generation: source selection with glitch-free
 * switchover, optional halving, bit/frame/output/timeout clocks, sample
 * strobe, locked loop reference choice, crystal oscillator control and
 * converter switching clocks, with the three control registers.
 * Assumes all clock pins are slow enough to be sampled as levels on
 * ref_clk and that register requests are synchronous one-cycle strobes.
 */
// How it works
// R1 - Source select bit picks pin or loop.
// R2 - Halving bit divides selected source by two.
// R3 - Switch only after old source falls.
// R4 - Host selects pin, then stops loop.
// R5 - Host starts loop, then selects it.
// R6 - Software reset reselects the master clock pin.
// R7 - Enable bit runs or stops crystal oscillator.
// R8 - Crystal runs by default, all power states.
// R9 - Crystal enable reachable at two locations.
// R10 - Sample strobe every 256 or 272 cycles.
// R11 - Host sizes bit clock for faster rate.
// R12 - Master clocks have fixed, repeatable phase.
// R13 - Slave clocks must arrive mutually synchronised.
// R14 - Output clock pin divides system clock.
// R15 - Alternate pins carry input-side clocks.
// R16 - Timeout clock runs only when enabled.
// R17 - Loop reference: pin, frame or crystal.
// R18 - Switching clocks come from RC oscillator.
// R19 - External 32k clock on crystal or pin.
// R20 - Output held low through the changeover; when halving, it holds the halving flop's level instead.
module ccg_codec_system_clock
    import ccg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire ccg_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    input wire logic sw_reset,
    input wire logic mclk_pin,
    input wire logic fll_clk,
    input wire logic lrclk_in,
    input wire logic gpio_adc_lrclk_in,
    input wire logic crystal_in_pin,
    input wire logic ext32k_on_xin,
    input wire logic gpio32k_sel,
    input wire logic gpio32k_in,
    input wire logic rc_osc_clk,
    output logic codec_system_clock,
    output logic sample_tick,
    output logic bit_clock,
    output logic bit_clock_oe,
    output logic dac_frame_clock,
    output logic dac_frame_clock_oe,
    output logic adc_bit_clock,
    output logic adc_frame_clock,
    output logic adc_frame_clock_inverted,
    output logic codec_output_clock,
    output logic timeout_clock,
    output logic locked_loop_enable,
    output logic locked_loop_osc_enable,
    output logic fll_ref_clk,
    output logic crystal_osc_enable,
    output logic crystal_out_pin,
    output logic crystal_out_pin_oe,
    output logic clk32k,
    output logic dcdc_clk_fast,
    output logic dcdc_clk_slow
);

    ccg_cfg_t cfg_r;
    logic xtal_en_r;
    ccg_sw_st_t sw_state_r;
    logic act_sel_r;
    logic mclk_prev_r;
    logic fll_prev_r;
    logic mux_prev_r;
    logic half_r;
    logic codec_system_clock_r;
    logic [8:0] fs_cnt_r;
    logic sample_tick_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic old_fall;
    logic new_lvl;
    logic gate_low;
    logic mux_lvl;
    logic mux_rise;
    logic half_nxt;
    logic sys_nxt;
    logic sys_edge;
    logic sys_rise;
    logic [8:0] fs_ratio;
    logic bclk_int;
    logic bclk_edge;
    logic frame_int;
    logic frame_int_b;
    logic bit_clock_r;
    logic bit_clock_oe_r;
    logic frame_r;
    logic frame_oe_r;
    logic adc_bclk_r;
    logic adc_frame_r;
    logic adc_frame_b_r;
    logic fll_ref_r;
    logic xtal_run_r;
    logic xout_r;
    logic xout_oe_r;
    logic clk32k_r;
    logic rc_prev_r;
    logic dcdc_fast_r;
    logic dcdc_slow_r;
    logic slave_frame;

    // Bit clock period in system clock edges; fractional ratios become odd counts.
    function automatic logic [DIV_W-1:0] bclk_period(input logic [3:0] code);
        logic [6:0] e;
        e = 7'h40;
        case (code)
            4'h0: e = 7'h02;
            4'h1: e = 7'h03;
            4'h2: e = 7'h04;
            4'h3: e = 7'h06;
            4'h4: e = 7'h08;
            4'h5: e = 7'h0b;
            4'h6: e = 7'h0c;
            4'h7: e = 7'h10;
            4'h8: e = 7'h16;
            4'h9: e = 7'h18;
            4'ha: e = 7'h20;
            4'hb: e = 7'h2c;
            4'hc: e = 7'h30;
            default: e = 7'h40;
        endcase
        return {17'h00000, e};
    endfunction

    // Control fields; a software reset restores defaults, the source to the pin.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r <= CFG_RST;
        end else if (sw_reset) begin
            cfg_r <= CFG_RST; // [R6] [R1]
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                PWR5_ADDR: begin
                    cfg_r.fll_en <= reg_req.wdata[PWR5_FLL_EN_BIT];
                    cfg_r.fll_osc <= reg_req.wdata[PWR5_FLL_OSC_BIT];
                    cfg_r.master <= reg_req.wdata[PWR5_MASTER_BIT];
                    cfg_r.fll_ref <= reg_req.wdata[PWR5_REF_LSB +: 2];
                end
                CLKSEL_ADDR: begin
                    cfg_r.op_div <= reg_req.wdata[CS_OPDIV_LSB +: 4];
                    cfg_r.bclk_div <= reg_req.wdata[CS_BCLK_LSB +: 4];
                    cfg_r.half <= reg_req.wdata[CS_HALF_BIT];
                    cfg_r.alt <= reg_req.wdata[CS_ALT_BIT];
                    cfg_r.opclk_en <= reg_req.wdata[CS_OPCLK_BIT];
                    cfg_r.src <= reg_req.wdata[CS_SRC_BIT]; // [R1]
                    cfg_r.usb <= reg_req.wdata[CS_USB_BIT];
                    cfg_r.to_rate <= reg_req.wdata[CS_TO_RATE_LSB +: 2];
                    cfg_r.to_en <= reg_req.wdata[CS_TO_EN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // The crystal enable lives in the always-on domain, so software reset leaves it.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            xtal_en_r <= XTAL_EN_RST; // [R8]
        end else if (reg_req.wr && reg_req.addr == PWR5_ADDR) begin
            xtal_en_r <= reg_req.wdata[PWR5_XTAL_BIT]; // [R9]
        end else if (reg_req.wr && reg_req.addr == RTCTICK_ADDR) begin
            xtal_en_r <= reg_req.wdata[RTC_XTAL_BIT]; // [R9]
        end
    end

    // Read data; unmapped addresses and reserved bits read as zero.
    always_comb begin
        rdata_nxt = 16'h0000;
        case (reg_req.addr)
            PWR5_ADDR: begin
                rdata_nxt[PWR5_FLL_EN_BIT] = cfg_r.fll_en;
                rdata_nxt[PWR5_FLL_OSC_BIT] = cfg_r.fll_osc;
                rdata_nxt[PWR5_MASTER_BIT] = cfg_r.master;
                rdata_nxt[PWR5_REF_LSB +: 2] = cfg_r.fll_ref;
                rdata_nxt[PWR5_XTAL_BIT] = xtal_en_r; // [R9]
                rdata_nxt[PWR5_ACT_BIT] = act_sel_r;
                rdata_nxt[PWR5_BUSY_BIT] = sw_state_r != SW_RUN;
            end
            CLKSEL_ADDR: begin
                rdata_nxt[CS_OPDIV_LSB +: 4] = cfg_r.op_div;
                rdata_nxt[CS_BCLK_LSB +: 4] = cfg_r.bclk_div;
                rdata_nxt[CS_HALF_BIT] = cfg_r.half;
                rdata_nxt[CS_ALT_BIT] = cfg_r.alt;
                rdata_nxt[CS_OPCLK_BIT] = cfg_r.opclk_en;
                rdata_nxt[CS_SRC_BIT] = cfg_r.src;
                rdata_nxt[CS_USB_BIT] = cfg_r.usb;
                rdata_nxt[CS_TO_RATE_LSB +: 2] = cfg_r.to_rate;
                rdata_nxt[CS_TO_EN_BIT] = cfg_r.to_en;
            end
            RTCTICK_ADDR: rdata_nxt[RTC_XTAL_BIT] = xtal_en_r; // [R9]
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // Read data is captured on the read strobe and held until the next one.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
        end else if (reg_req.rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Edge detection on the active and standby sources.
    always_comb begin
        old_fall = act_sel_r ? (fll_prev_r & ~fll_clk) : (mclk_prev_r & ~mclk_pin);
        new_lvl = act_sel_r ? mclk_pin : fll_clk;
        gate_low = (sw_state_r == SW_WAIT_NEW_LOW) || (sw_state_r == SW_WAIT_OLD_FALL && old_fall);
        mux_lvl = gate_low ? 1'h0 : (act_sel_r ? fll_clk : mclk_pin); // [R1] [R20]
        mux_rise = mux_lvl & ~mux_prev_r;
        half_nxt = mux_rise ? ~half_r : half_r;
        sys_nxt = cfg_r.half ? half_nxt : mux_lvl; // [R2]
        sys_edge = sys_nxt != codec_system_clock_r;
        sys_rise = sys_nxt & ~codec_system_clock_r;
    end

    // Switchover: wait for the old source to fall, then for the new one to be low.
    // A loop that is stopped after deselection gives the falling edge needed here.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_state_r <= SW_RUN;
            act_sel_r <= 1'h0;
        end else begin
            case (sw_state_r)
                SW_RUN: begin
                    if (cfg_r.src != act_sel_r) begin
                        sw_state_r <= SW_WAIT_OLD_FALL;
                    end
                end
                SW_WAIT_OLD_FALL: begin
                    if (cfg_r.src == act_sel_r) begin
                        sw_state_r <= SW_RUN;
                    end else if (old_fall) begin
                        sw_state_r <= SW_WAIT_NEW_LOW; // [R3] [R4]
                    end
                end
                SW_WAIT_NEW_LOW: begin
                    if (!new_lvl) begin
                        act_sel_r <= ~act_sel_r; // [R3] [R20]
                        sw_state_r <= SW_RUN;
                    end
                end
                default: sw_state_r <= SW_RUN;
            endcase
        end
    end

    // Source history, halving flop and the system clock itself.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mclk_prev_r <= 1'h0;
            fll_prev_r <= 1'h0;
            mux_prev_r <= 1'h0;
            half_r <= 1'h0;
            codec_system_clock_r <= 1'h0;
        end else begin
            mclk_prev_r <= mclk_pin;
            fll_prev_r <= fll_clk;
            mux_prev_r <= mux_lvl;
            half_r <= half_nxt; // [R2]
            codec_system_clock_r <= sys_nxt;
        end
    end

    // Sample strobe per internal clock rising edges; the mode picks the ratio.
    assign fs_ratio = cfg_r.usb ? FS_RATIO_USB : FS_RATIO_NORMAL; // [R10]

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_cnt_r <= 9'h000;
            sample_tick_r <= 1'h0;
        end else if (sys_rise) begin
            if (fs_cnt_r >= fs_ratio - 9'h001) begin
                fs_cnt_r <= 9'h000; // [R10]
                sample_tick_r <= 1'h1;
            end else begin
                fs_cnt_r <= fs_cnt_r + 9'h001;
                sample_tick_r <= 1'h0;
            end
        end else begin
            sample_tick_r <= 1'h0;
        end
    end

    // Bit and frame dividers restart together whenever master mode starts.
    ccg_divider u_bclk (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(cfg_r.master), // [R12]
        .tick(sys_edge),
        .period(bclk_period(cfg_r.bclk_div)),
        .clk_out(bclk_int),
        .clk_out_b(),
        .out_edge(bclk_edge)
    );

    ccg_divider u_frame (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(cfg_r.master), // [R12]
        .tick(bclk_edge),
        .period(FRAME_PERIOD_EDGES),
        .clk_out(frame_int),
        .clk_out_b(frame_int_b),
        .out_edge()
    );

    ccg_divider u_opclk (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(cfg_r.opclk_en), // [R14]
        .tick(sys_edge),
        .period({18'h00000, {1'h0, cfg_r.op_div} + 5'h01, 1'h0}),
        .clk_out(codec_output_clock),
        .clk_out_b(),
        .out_edge()
    );

    ccg_divider u_toclk (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(cfg_r.to_en), // [R16]
        .tick(sys_edge),
        .period(TOCLK_BASE_EDGES << cfg_r.to_rate),
        .clk_out(timeout_clock),
        .clk_out_b(),
        .out_edge()
    );

    // Pin routing: with alternate pins the main pair serves playback only.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_clock_r <= 1'h0;
            bit_clock_oe_r <= 1'h0;
            frame_r <= 1'h0;
            frame_oe_r <= 1'h0;
            adc_bclk_r <= 1'h0;
            adc_frame_r <= 1'h0;
            adc_frame_b_r <= 1'h0;
        end else begin
            bit_clock_r <= bclk_int;
            bit_clock_oe_r <= cfg_r.master; // [R12]
            frame_r <= frame_int;
            frame_oe_r <= cfg_r.master;
            adc_bclk_r <= cfg_r.alt & bclk_int; // [R15]
            adc_frame_r <= cfg_r.alt & frame_int; // [R15]
            adc_frame_b_r <= cfg_r.alt & frame_int_b; // [R15]
        end
    end

    // In slave mode the input-side frame clock comes from the alternate pin when used.
    assign slave_frame = cfg_r.alt ? gpio_adc_lrclk_in : lrclk_in; // [R13] [R15]

    // Loop reference, crystal control and the 32k selection.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fll_ref_r <= 1'h0;
            xtal_run_r <= 1'h0;
            xout_r <= 1'h0;
            xout_oe_r <= 1'h0;
            clk32k_r <= 1'h0;
        end else begin
            case (cfg_r.fll_ref)
                2'h0: fll_ref_r <= mclk_pin; // [R17]
                2'h1: fll_ref_r <= ~cfg_r.master & slave_frame; // [R17]
                2'h2: fll_ref_r <= clk32k_r; // [R17]
                default: fll_ref_r <= 1'h0;
            endcase
            xtal_run_r <= xtal_en_r; // [R7] [R8]
            xout_r <= ~crystal_in_pin;
            xout_oe_r <= xtal_en_r & ~ext32k_on_xin; // [R7] [R19]
            if (gpio32k_sel) begin
                clk32k_r <= gpio32k_in; // [R19]
            end else begin
                clk32k_r <= (xtal_en_r | ext32k_on_xin) & crystal_in_pin; // [R19]
            end
        end
    end

    // Converter switching clocks follow the RC oscillator; no external clock needed.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rc_prev_r <= 1'h0;
            dcdc_fast_r <= 1'h0;
            dcdc_slow_r <= 1'h0;
        end else begin
            rc_prev_r <= rc_osc_clk;
            dcdc_fast_r <= rc_osc_clk; // [R18]
            if (rc_osc_clk && !rc_prev_r) begin
                dcdc_slow_r <= ~dcdc_slow_r; // [R18]
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign codec_system_clock = codec_system_clock_r;
    assign sample_tick = sample_tick_r;
    assign bit_clock = bit_clock_r;
    assign bit_clock_oe = bit_clock_oe_r;
    assign dac_frame_clock = frame_r;
    assign dac_frame_clock_oe = frame_oe_r;
    assign adc_bit_clock = adc_bclk_r;
    assign adc_frame_clock = adc_frame_r;
    assign adc_frame_clock_inverted = adc_frame_b_r;
    assign locked_loop_enable = cfg_r.fll_en; // [R5]
    assign locked_loop_osc_enable = cfg_r.fll_osc;
    assign fll_ref_clk = fll_ref_r;
    assign crystal_osc_enable = xtal_run_r;
    assign crystal_out_pin = xout_r;
    assign crystal_out_pin_oe = xout_oe_r;
    assign clk32k = clk32k_r;
    assign dcdc_clk_fast = dcdc_fast_r;
    assign dcdc_clk_slow = dcdc_slow_r;

    // Checks on the switchover sequence and the derived clocks.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_old_fell;
        sw_state_r == SW_WAIT_OLD_FALL && cfg_r.src != act_sel_r && old_fall;
    endsequence

    sequence s_new_low;
        sw_state_r == SW_WAIT_NEW_LOW && !new_lvl;
    endsequence

    chk_fall_then_gap: assert property (s_old_fell |=> sw_state_r == SW_WAIT_NEW_LOW) // [R3]
        else $error("old source fall did not start the gap");
    chk_switch_cause: assert property ($changed(act_sel_r) |-> $past(sw_state_r == SW_WAIT_NEW_LOW && !new_lvl)) // [R3]
        else $error("source switched without the safe sequence");
    chk_gap_low: assert property (s_new_low ##0 !cfg_r.half |=> !codec_system_clock_r ##1 act_sel_r == $past(act_sel_r)) // [R20]
        else $error("system clock not low across changeover");
    chk_pin_follow: assert property (sw_state_r == SW_RUN && !act_sel_r && !cfg_r.half && !old_fall
        |=> codec_system_clock_r == $past(mclk_pin)) // [R1]
        else $error("system clock does not follow master clock pin");
    chk_half_rise: assert property (cfg_r.half && $past(cfg_r.half) && $rose(codec_system_clock_r)
        |-> $past(mux_rise) && !$past(half_r)) // [R2]
        else $error("halved clock rose without a source rise");
    chk_swreset_src: assert property (sw_reset |=> !cfg_r.src) // [R6]
        else $error("software reset did not reselect the pin");
    chk_xtal_alias: assert property (reg_req.wr && reg_req.addr == RTCTICK_ADDR
        |=> xtal_en_r == $past(reg_req.wdata[RTC_XTAL_BIT]) ##1 crystal_osc_enable == $past(xtal_en_r)) // [R9] [R7]
        else $error("crystal enable alias not shared");
    chk_fs_period: assert property (sample_tick_r && $past(fs_cnt_r) < $past(fs_ratio)
        |-> $past(fs_cnt_r) == $past(fs_ratio) - 9'h001) // [R10]
        else $error("sample strobe at wrong count");
    chk_toclk_idle: assert property (!cfg_r.to_en |=> !timeout_clock) // [R16]
        else $error("timeout clock ran while disabled");
    chk_opclk_idle: assert property (!cfg_r.opclk_en |=> !codec_output_clock) // [R14]
        else $error("output clock ran while not selected");
    chk_alt_pins: assert property (!cfg_r.alt |=> !adc_bit_clock && !adc_frame_clock && !adc_frame_clock_inverted) // [R15]
        else $error("alternate pins driven while unused");
    chk_master_oe: assert property (bit_clock_oe_r == $past(cfg_r.master) && dac_frame_clock_oe == bit_clock_oe_r) // [R12]
        else $error("pin drive does not track master mode");

endmodule

// *** verification/ccg_clk_src.sv ***
/* Clock sources beyond the block: the master clock pin and the locked loop output.
   Assumes the bench enables the loop output from the two loop enables. */
module ccg_clk_src (
    input wire logic ref_clk,
    input wire logic fll_run,
    output logic mclk_pin,
    output logic fll_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    int m = 0;
    int f = 0;
    // The loop finishes its period when disabled, so a last falling edge follows unless it stops with the count at zero.
    always @(posedge ref_clk) begin
        m <= (m + 1) % 6;
        f <= (fll_run || f != 0) ? (f + 1) % 10 : 0;
    end
    assign mclk_pin = (m < 3);
    assign fll_clk = (f >= 5);
endmodule

// *** verification/ccg_codec_system_clock_tb.sv ***
/* Bench for the codec system clock block: registers, source switching, dividers, strobe.
   Assumes the source model makes pin clock period 6 and loop clock period 10. */
module ccg_codec_system_clock_tb
    import ccg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0;
    logic rst_b = 0;
    logic sw_reset = 0;
    logic [7:0] cnt = 0;
    ccg_reg_req_t reg_req = '0;
    logic [15:0] reg_rdata;
    logic mclk, freq_locked_loop, sys, tick, opclk, lle, lloe, xen, bclk, fref;
    wire [3:0] mon = {fref, bclk, opclk, sys};
    int n_fail = 0;
    int n_checks = 0;
    int k;
    always #2 ref_clk = ~ref_clk;
    // Slow stand-ins keep the crystal, RC and slave frame inputs moving.
    always @(posedge ref_clk) cnt <= cnt + 8'h01;
    ccg_clk_src src (.ref_clk(ref_clk), .fll_run(lle & lloe), .mclk_pin(mclk), .fll_clk(freq_locked_loop));
    ccg_codec_system_clock uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sw_reset(sw_reset), .mclk_pin(mclk), .fll_clk(freq_locked_loop), .lrclk_in(cnt[4]), .gpio_adc_lrclk_in(1'b0),
        .crystal_in_pin(cnt[7]), .ext32k_on_xin(1'b0), .gpio32k_sel(1'b0), .gpio32k_in(1'b0),
        .rc_osc_clk(cnt[3]), .codec_system_clock(sys), .sample_tick(tick), .bit_clock(bclk), .bit_clock_oe(),
        .dac_frame_clock(), .dac_frame_clock_oe(), .adc_bit_clock(), .adc_frame_clock(),
        .adc_frame_clock_inverted(), .codec_output_clock(opclk), .timeout_clock(),
        .locked_loop_enable(lle), .locked_loop_osc_enable(lloe), .fll_ref_clk(fref), .crystal_osc_enable(xen),
        .crystal_out_pin(), .crystal_out_pin_oe(), .clk32k(), .dcdc_clk_fast(), .dcdc_clk_slow());
    task automatic results();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One register cycle; a read answer is taken one edge after the strobe.
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk) reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk) reg_req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(reg_rdata, e);
    endtask
    // Counts rises of mon[sel]: system, output, bit clock or loop reference.
    task automatic rises(input int sel, input int cyc, input logic [15:0] e);
        int r = 0;
        logic p;
        p = mon[sel];
        repeat (cyc) begin
            @(posedge ref_clk) #1;
            r += int'(mon[sel] & !p);
            p = mon[sel];
        end
        chk(16'(r), e);
    endtask
    // Polls the busy bit; a switch that never ends is counted as a failure.
    task automatic settle();
        for (k = 0; k < 100; k++) begin
            acc(1'b0, PWR5_ADDR, 16'h0000);
            if (reg_rdata[PWR5_BUSY_BIT] === 1'b0) break;
        end
        if (k == 100) begin
            n_fail++;
            results();
        end
    endtask
    task automatic tick_gap(input logic [15:0] e);
        for (k = 0; k < 4000 && tick !== 1'b1; k++) @(posedge ref_clk) #1;
        if (k == 4000) begin
            n_fail++;
            results();
        end
        for (k = 1; k < 4000; k++) begin
            @(posedge ref_clk) #1;
            if (tick === 1'b1) break;
        end
        chk(16'(k), e);
        if (k == 4000) results();
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(PWR5_ADDR, 16'h0400);
        rd(RTCTICK_ADDR, 16'h1000);
        rd(CLKSEL_ADDR, 16'h0000);
        acc(1'b1, RTCTICK_ADDR, 16'h0000);
        rd(PWR5_ADDR, 16'h0000);
        chk(16'(xen), 16'h0000);
        acc(1'b1, PWR5_ADDR, 16'h0400);
        rd(RTCTICK_ADDR, 16'h1000);
        rd(8'h30, 16'h0000);
        rises(1'b0, 60, 16'h000a);
        acc(1'b1, CLKSEL_ADDR, 16'h0401);
        rises(1'b1, 72, 16'h0006);
        acc(1'b1, CLKSEL_ADDR, 16'h0100);
        repeat (30) @(posedge ref_clk);
        rises(1'b0, 60, 16'h0005);
        rises(1'b1, 36, 16'h0000);
        acc(1'b1, CLKSEL_ADDR, 16'h0000);
        tick_gap(16'h0600);
        acc(1'b1, CLKSEL_ADDR, 16'h1000);
        tick_gap(16'h0660);
        // Host order: oscillator, then loop, then source select.
        acc(1'b1, PWR5_ADDR, 16'h0402);
        acc(1'b1, PWR5_ADDR, 16'h0403);
        acc(1'b1, CLKSEL_ADDR, 16'h0800);
        settle();
        rd(PWR5_ADDR, 16'h4403);
        rises(1'b0, 60, 16'h0006);
        acc(1'b1, CLKSEL_ADDR, 16'h0000);
        acc(1'b1, PWR5_ADDR, 16'h0402);
        acc(1'b1, PWR5_ADDR, 16'h0400);
        settle();
        rd(PWR5_ADDR, 16'h0400);
        rises(1'b0, 60, 16'h000a);
        acc(1'b1, PWR5_ADDR, 16'h0403);
        acc(1'b1, CLKSEL_ADDR, 16'h0800);
        settle();
        @(posedge ref_clk) sw_reset <= 1'b1;
        @(posedge ref_clk) sw_reset <= 1'b0;
        settle();
        rd(CLKSEL_ADDR, 16'h0000);
        rd(PWR5_ADDR, 16'h0400);
        // Slave frame from a bench counter, in step with the clock, as loop reference.
        acc(1'b1, PWR5_ADDR, 16'h0410);
        acc(1'b1, CLKSEL_ADDR, 16'h0020);
        rises(3, 64, 16'h0002);
        acc(1'b1, PWR5_ADDR, 16'h0404);
        rises(2, 72, 16'h0006);
        results();
    end
endmodule
